/* File: mtd_top.v */
// Purpose: freefall/motion and transient event detection for a
//          three-axis accelerometer, register side included
// Assumes: host register access arrives as a decoded read/write port
//          from the serial interface logic on MCLK; axis samples are
//          signed 12-bit at 16 counts per threshold count, a scale of 0.063 g / 16 counts
// Notes:   sample timing comes from an internal output-rate divider
`include "mtd_defs.vh"

module mtd_top #(
    parameter        SW       = 12,
    // scale lets a simulation shorten every sample period
    parameter [23:0] STEP_DIV = 24'h000001
) (
    // clock and reset
    input  wire          MCLK,
    input  wire          NRST,
    // register port
    input  wire          REG_WR,
    input  wire          REG_RD,
    input  wire [7:0]    REG_ADDR,
    input  wire [7:0]    REG_WDATA,
    output wire [7:0]    REG_RDATA,
    // samples, {z, y, x}, raw and high-pass filtered
    input  wire [3*SW-1:0] RAW_DATA,
    input  wire [3*SW-1:0] HPF_DATA,
    // detector outputs
    output wire          SAMPLE_STEP,
    output wire          MOTION_EVENT,
    output wire          TRANSIENT_EVENT
);

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    reg  [7:0]  mcfg_q;
    reg  [7:0]  motion_threshold_reg_q;
    reg  [7:0]  motion_debounce_count_reg_q;
    reg  [4:0]  tcfg_q;
    reg  [7:0]  transient_threshold_reg_q;
    reg  [7:0]  tcount_q;
    reg  [7:0]  sys_ctrl_q;
    reg  [7:0]  msrc_q;
    reg  [6:0]  tsrc_q;
    reg  [7:0]  rdata_q;

    wire        debounce_clear_mode = motion_threshold_reg_q[7];
    wire [6:0]  threshold_field     = motion_threshold_reg_q[6:0];
    wire        t_clear_mode        = transient_threshold_reg_q[7];
    wire        low_noise           = sys_ctrl_q[`MTD_CTRL_LNOISE_BIT];
    wire [2:0]  output_data_rate    = sys_ctrl_q[5:3];
    wire [1:0]  over_mode           = sys_ctrl_q[1:0];
    wire        event_latch_enable  = tcfg_q[`MTD_TCFG_LATCH_BIT];
    wire        z_transient_enable  = tcfg_q[3];
    wire        y_transient_enable  = tcfg_q[2];
    wire        x_transient_enable  = tcfg_q[1];
    wire        filter_bypass       = tcfg_q[`MTD_TCFG_BYPASS_BIT];
    wire        m_latch             = mcfg_q[`MTD_CFG_LATCH_BIT];
    wire        combination_select  = mcfg_q[`MTD_CFG_COMB_BIT];

    wire        rd_tsrc = REG_RD && (REG_ADDR == `MTD_ADDR_TRANS_SRC);
    wire        rd_msrc = REG_RD && (REG_ADDR == `MTD_ADDR_MOTION_SRC);

    // -------------------------------------------------------------------
    // sample period divider
    // -------------------------------------------------------------------
    // periods kept at 32 bits, cut to the divider's width after scaling
    localparam [31:0] C800  = `MTD_US2CYC(`MTD_STEP_US_800);
    localparam [31:0] C400  = `MTD_US2CYC(`MTD_STEP_US_400);
    localparam [31:0] C200  = `MTD_US2CYC(`MTD_STEP_US_200);
    localparam [31:0] C100  = `MTD_US2CYC(`MTD_STEP_US_100);
    localparam [31:0] C50   = `MTD_US2CYC(`MTD_STEP_US_50);
    localparam [31:0] CLPLN = `MTD_US2CYC(`MTD_STEP_US_LOW_NOISE_LOW_POWER_MODE);
    localparam [31:0] CLP   = `MTD_US2CYC(`MTD_STEP_US_LP);

    function [31:0] period;
        input [2:0] rate;
        input [1:0] mode;
        begin
            case (rate)
                3'h0:    period = C800;
                3'h1:    period = C400;
                3'h2:    period = C200;
                3'h3:    period = C100;
                3'h4:    period = C50;
                default: period = C50;
            endcase
            if (mode == `MTD_MODE_HIRES && rate >= 3'h2)
                period = C400;
            else if (rate >= 3'h5 && mode == `MTD_MODE_LOW_NOISE_LOW_POWER_MODE)
                period = CLPLN;
            else if (rate == 3'h5 && mode == `MTD_MODE_LP)
                period = CLPLN;
            else if (rate >= 3'h6 && mode == `MTD_MODE_LP)
                period = CLP;
        end
    endfunction

    reg  [23:0] div_q;
    wire [31:0] per_full = period(output_data_rate, over_mode) / STEP_DIV;
    wire [23:0] per      = per_full[23:0];
    wire        step = (div_q + 24'h000001 >= per);

    always @(posedge MCLK or negedge NRST) begin
        if (!NRST)
            div_q <= 24'h000000;
        else if (step)
            div_q <= 24'h000000;
        else
            div_q <= div_q + 24'h000001;
    end

    // -------------------------------------------------------------------
    // per-axis magnitudes and comparisons
    // -------------------------------------------------------------------
    // samples carry 1/16 of a threshold count per lsb at the 8 g range
    wire [6:0] ths_lim = low_noise ? `MTD_THS_MAX_4G
                                   : `MTD_THS_MAX_8G;
    wire [6:0] m_ths = (threshold_field > ths_lim) ? ths_lim
                                                   : threshold_field;
    wire [6:0] t_ths0 = transient_threshold_reg_q[6:0];
    wire [6:0] t_ths = (t_ths0 > ths_lim) ? ths_lim : t_ths0;

    wire [2:0] m_above;
    wire [2:0] m_neg;
    wire [2:0] t_above;
    wire [2:0] t_neg;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : axis
            wire [SW-1:0] r = RAW_DATA[g*SW +: SW];
            wire [SW-1:0] h = filter_bypass ? r
                                            : HPF_DATA[g*SW +: SW];
            wire [SW-1:0] rm = r[SW-1] ? (~r + 1'b1) : r;
            wire [SW-1:0] hm = h[SW-1] ? (~h + 1'b1) : h;
            // full 8 g comparison on the top 7 magnitude bits
            assign m_above[g] = rm[SW-2:SW-8] > m_ths;
            assign m_neg[g]   = r[SW-1];
            assign t_above[g] = hm[SW-2:SW-8] > t_ths;
            assign t_neg[g]   = h[SW-1];
        end
    endgenerate

    // -------------------------------------------------------------------
    // freefall / motion
    // -------------------------------------------------------------------
    wire [2:0] m_en = mcfg_q[5:3];
    wire       m_cond = combination_select
                      ? |(m_above & m_en)
                      : ~|(m_above & m_en) & (m_en != 3'h0);
    wire       m_hit;

    mtd_debounce #(.W(8)) u_mdeb (
        .MCLK       (MCLK),
        .NRST       (NRST),
        .step       (step),
        .cond       (m_cond),
        .clear_mode (debounce_clear_mode),
        .limit      (motion_debounce_count_reg_q),
        .hit        (m_hit)
    );

    wire [5:0] m_axis_bits = {m_above[2] & m_en[2], m_neg[2] & m_en[2],
                              m_above[1] & m_en[1], m_neg[1] & m_en[1],
                              m_above[0] & m_en[0], m_neg[0] & m_en[0]};

    // -------------------------------------------------------------------
    // transient
    // -------------------------------------------------------------------
    wire [2:0] t_en = {z_transient_enable, y_transient_enable,
                       x_transient_enable};
    wire [2:0] t_ax = t_above & t_en;
    wire       t_hit;

    mtd_debounce #(.W(8)) u_tdeb (
        .MCLK       (MCLK),
        .NRST       (NRST),
        .step       (step),
        .cond       (|t_ax),
        .clear_mode (t_clear_mode),
        .limit      (tcount_q),
        .hit        (t_hit)
    );

    wire       event_active = tsrc_q[6];
    reg  [6:0] tsrc_d;
    integer    k;

    always @* begin
        tsrc_d = tsrc_q;
        if (rd_tsrc)
            tsrc_d = 7'h00;
        if (event_latch_enable) begin
            if (t_hit) begin
                // active: flags may only set, polarity follows
                for (k = 0; k < 3; k = k + 1) begin
                    if (t_ax[k] && (!event_active || rd_tsrc ||
                                    !tsrc_d[2*k+1]
                                    || event_active)) begin
                        tsrc_d[2*k+1] = 1'b1;
                        tsrc_d[2*k]   = t_neg[k];
                    end
                end
                tsrc_d[6] = 1'b1;
            end
            // otherwise bits stay frozen until read
        end else if (step) begin
            for (k = 0; k < 3; k = k + 1) begin
                tsrc_d[2*k+1] = t_hit & t_ax[k];
                tsrc_d[2*k]   = t_hit & t_ax[k] & t_neg[k];
            end
            tsrc_d[6] = t_hit & (|t_ax);
        end
    end

    // -------------------------------------------------------------------
    // motion source
    // -------------------------------------------------------------------
    reg [7:0] msrc_d;

    always @* begin
        msrc_d = msrc_q;
        if (rd_msrc)
            msrc_d = 8'h00;
        if (m_latch) begin
            if (m_hit && !(msrc_q[7] && !rd_msrc))
                msrc_d = {1'b1, 1'b0, m_axis_bits};
        end else if (step) begin
            msrc_d = m_hit ? {1'b1, 1'b0, m_axis_bits} : 8'h00;
        end
    end

    // -------------------------------------------------------------------
    // register writes and reads
    // -------------------------------------------------------------------
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            mcfg_q                      <= `MTD_RST_REG;
            motion_threshold_reg_q      <= `MTD_RST_REG;
            motion_debounce_count_reg_q <= `MTD_RST_REG;
            tcfg_q                      <= 5'h00;
            transient_threshold_reg_q   <= `MTD_RST_REG;
            tcount_q                    <= `MTD_RST_REG;
            sys_ctrl_q                  <= `MTD_RST_REG;
            msrc_q                      <= `MTD_RST_REG;
            tsrc_q                      <= 7'h00;
            rdata_q                     <= `MTD_RST_REG;
        end else begin
            msrc_q <= msrc_d;
            tsrc_q <= tsrc_d;
            if (REG_WR) begin
                case (REG_ADDR)
                    `MTD_ADDR_MOTION_CFG:
                        mcfg_q <= {REG_WDATA[7:3], 3'h0};
                    `MTD_ADDR_MOTION_THS:
                        motion_threshold_reg_q <= REG_WDATA;
                    `MTD_ADDR_MOTION_COUNT:
                        motion_debounce_count_reg_q <= REG_WDATA;
                    `MTD_ADDR_TRANS_CFG:
                        tcfg_q <= REG_WDATA[4:0];
                    `MTD_ADDR_TRANS_THS:
                        transient_threshold_reg_q <= REG_WDATA;
                    `MTD_ADDR_TRANS_COUNT:
                        tcount_q <= REG_WDATA;
                    `MTD_ADDR_SYS_CTRL:
                        sys_ctrl_q <= REG_WDATA;
                    default: ;
                endcase
            end
            if (REG_RD) begin
                case (REG_ADDR)
                    `MTD_ADDR_MOTION_CFG:   rdata_q <= mcfg_q;
                    `MTD_ADDR_MOTION_SRC:   rdata_q <= msrc_q;
                    `MTD_ADDR_MOTION_THS:   rdata_q <= motion_threshold_reg_q;
                    `MTD_ADDR_MOTION_COUNT:
                        rdata_q <= motion_debounce_count_reg_q;
                    `MTD_ADDR_TRANS_CFG:    rdata_q <= {3'h0, tcfg_q};
                    `MTD_ADDR_TRANS_SRC:
                        rdata_q <= {1'b0, tsrc_q};
                    `MTD_ADDR_TRANS_THS:
                        rdata_q <= transient_threshold_reg_q;
                    `MTD_ADDR_TRANS_COUNT:  rdata_q <= tcount_q;
                    `MTD_ADDR_SYS_CTRL:     rdata_q <= sys_ctrl_q;
                    default:                rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign REG_RDATA       = rdata_q;
    assign SAMPLE_STEP     = step;
    assign MOTION_EVENT    = msrc_q[7];
    assign TRANSIENT_EVENT = tsrc_q[6];

endmodule

/* File: mtd_defs.vh */
// Purpose: register offsets, field positions, reset values and timing
//          counts for the motion and transient event detector
// Assumes: 40 MHz MCLK
// Notes:   definitions only
`ifndef MTD_DEFS_VH
`define MTD_DEFS_VH

// -----------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------
`define MTD_ADDR_MOTION_CFG    8'h15
`define MTD_ADDR_MOTION_SRC    8'h16
`define MTD_ADDR_MOTION_THS    8'h17
`define MTD_ADDR_MOTION_COUNT  8'h18
`define MTD_ADDR_TRANS_CFG     8'h1D
`define MTD_ADDR_TRANS_SRC     8'h1E
`define MTD_ADDR_TRANS_THS     8'h1F
`define MTD_ADDR_TRANS_COUNT   8'h20
`define MTD_ADDR_SYS_CTRL      8'h2A

// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define MTD_THS_CLR_MODE_BIT   7
`define MTD_CFG_LATCH_BIT      7
`define MTD_CFG_COMB_BIT       6
`define MTD_CFG_ZEN_BIT        5
`define MTD_TCFG_LATCH_BIT     4
`define MTD_TCFG_ZEN_BIT       3
`define MTD_TCFG_BYPASS_BIT    0
`define MTD_SRC_EA_MOTION_BIT  7
`define MTD_SRC_EA_TRANS_BIT   6
`define MTD_CTRL_LNOISE_BIT    2
`define MTD_CTRL_ODR_LSB       3

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define MTD_RST_REG            8'h00

// -----------------------------------------------------------------------
// threshold limits, counts of 0.063 g
// -----------------------------------------------------------------------
`define MTD_THS_MAX_8G         7'h7F
`define MTD_THS_MAX_4G         7'h3F

// -----------------------------------------------------------------------
// sample periods in microseconds and the cycles they take
// -----------------------------------------------------------------------
`define MTD_CLK_KHZ            40000
`define MTD_STEP_US_800        1250
`define MTD_STEP_US_400        2500
`define MTD_STEP_US_200        5000
`define MTD_STEP_US_100        10000
`define MTD_STEP_US_50         20000
`define MTD_STEP_US_LOW_NOISE_LOW_POWER_MODE       80000
`define MTD_STEP_US_LP         160000
// cycles per microsecond first, so the slow periods stay inside 32 bits
`define MTD_US2CYC(us)         ((us) * (`MTD_CLK_KHZ / 1000))

// oversampling modes
`define MTD_MODE_NORMAL        2'h0
`define MTD_MODE_LOW_NOISE_LOW_POWER_MODE          2'h1
`define MTD_MODE_HIRES         2'h2
`define MTD_MODE_LP            2'h3

`endif

/* File: mtd_debounce.v */
// Purpose: one debounce counter for an inertial condition
// Assumes: step is a one-cycle pulse per output sample
// Notes:   counter saturates at the programmed limit
`include "mtd_defs.vh"

module mtd_debounce #(
    parameter W = 8
) (
    // clock and reset
    input  wire         MCLK,
    input  wire         NRST,
    // control
    input  wire         step,
    input  wire         cond,
    input  wire         clear_mode,
    input  wire [W-1:0] limit,
    // result
    output wire         hit
);

    reg  [W-1:0] cnt_q;
    reg  [W-1:0] cnt_d;

    // -------------------------------------------------------------------
    // counter
    // -------------------------------------------------------------------
    always @* begin
        cnt_d = cnt_q;
        if (step) begin
            if (cond) begin
                if (cnt_q < limit)
                    cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
                else
                    cnt_d = limit;
            end else if (clear_mode) begin
                cnt_d = {W{1'b0}};
            end else if (cnt_q != {W{1'b0}}) begin
                cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge MCLK or negedge NRST) begin
        if (!NRST)
            cnt_q <= {W{1'b0}};
        else
            cnt_q <= cnt_d;
    end

    // a zero limit fires on the first matching sample
    assign hit = step && cond && (cnt_d == limit);

endmodule

/* File: mtd_host.sv */
// Purpose: host model driving the decoded register port of the detector
// Assumes: one strobe per access, changed just after a rising edge
// Notes:   released address and data lines show the inverse of last value
module mtd_host (
    // clock
    input  wire        MCLK,
    // register port toward the device
    output logic       REG_WR,
    output logic       REG_RD,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    input  wire  [7:0] REG_RDATA
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_ADDR  = 8'h00;
        REG_WDATA = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        #1;
        REG_WR    = 1'b1;
        REG_ADDR  = a;
        REG_WDATA = d;
        @(posedge MCLK);
        #1;
        REG_WR    = 1'b0;
        REG_ADDR  = ~a;
        REG_WDATA = ~d;
    endtask

    // reading the source acknowledges latched events
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        #1;
        REG_RD   = 1'b1;
        REG_ADDR = a;
        @(posedge MCLK);
        #1;
        REG_RD   = 1'b0;
        REG_ADDR = ~a;
        d        = REG_RDATA;
    endtask
endmodule

/* File: mtd_monitor.sv */
// Purpose: port-level assertions for the motion and transient detector
// Assumes: events change only at sample steps or source reads
// Notes:   bound to the top module
module mtd_monitor #(
    parameter SW = 12
) (
    // clock and reset
    input wire            MCLK,
    input wire            NRST,
    // register port
    input wire            REG_WR,
    input wire            REG_RD,
    input wire [7:0]      REG_ADDR,
    input wire [7:0]      REG_WDATA,
    input wire [7:0]      REG_RDATA,
    // samples and detector outputs
    input wire [3*SW-1:0] RAW_DATA,
    input wire [3*SW-1:0] HPF_DATA,
    input wire            SAMPLE_STEP,
    input wire            MOTION_EVENT,
    input wire            TRANSIENT_EVENT
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);

    sequence s_src_rd;
        REG_RD && REG_ADDR == 8'h1E;
    endsequence
    // a read away from a step, so no new hit can win
    sequence s_trans_clr;
        s_src_rd ##0 !SAMPLE_STEP;
    endsequence
    sequence s_mot_clr;
        REG_RD && REG_ADDR == 8'h16 && !SAMPLE_STEP;
    endsequence

    a_step_pulse: assert property (SAMPLE_STEP |=> !SAMPLE_STEP)
        else $error("sample step wider than one cycle");
    a_rdata_holds: assert property (
        !REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (
        REG_RD && REG_ADDR > 8'h2A |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_src_bit7: assert property (s_src_rd |=> !REG_RDATA[7])
        else $error("transient source bit 7 set");
    a_ea_agree: assert property (
        s_src_rd |=> REG_RDATA[6] == $past(TRANSIENT_EVENT))
        else $error("event active differs from transient event");
    a_ea_flags: assert property (
        s_src_rd |=> REG_RDATA[6] ==
                     (REG_RDATA[5] | REG_RDATA[3] | REG_RDATA[1]))
        else $error("event active not the or of axis flags");
    a_mot_on_step: assert property (
        $rose(MOTION_EVENT) |-> $past(SAMPLE_STEP))
        else $error("motion event rose off a sample step");
    a_trans_on_step: assert property (
        $rose(TRANSIENT_EVENT) |-> $past(SAMPLE_STEP))
        else $error("transient event rose off a sample step");
    a_trans_rd_clear: assert property (
        s_trans_clr |=> !TRANSIENT_EVENT)
        else $error("transient source read did not clear");
    a_mot_rd_clear: assert property (s_mot_clr |=> !MOTION_EVENT)
        else $error("motion source read did not clear");
endmodule

bind mtd_top mtd_monitor #(.SW(SW)) u_mon (
    .MCLK(MCLK), .NRST(NRST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .RAW_DATA(RAW_DATA), .HPF_DATA(HPF_DATA), .SAMPLE_STEP(SAMPLE_STEP),
    .MOTION_EVENT(MOTION_EVENT), .TRANSIENT_EVENT(TRANSIENT_EVENT));

/* File: mtd_tb.sv */
// Purpose: self-checking bench for the motion and transient detector
// Assumes: divider shortened by 1000, so 800 Hz is 50 cycles a sample
// Notes:   axis data changes just after a step edge
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk, nrst;
    logic [35:0] raw, hpf;
    logic [7:0]  d;
    wire         reg_wr, reg_rd, step, mev, tev;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
    int          err_total, cmp_count, cyc;

    mtd_top #(.SW(12), .STEP_DIV(24'h0003E8)) uut (
        .MCLK(mclk), .NRST(nrst), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .RAW_DATA(raw), .HPF_DATA(hpf), .SAMPLE_STEP(step),
        .MOTION_EVENT(mev), .TRANSIENT_EVENT(tev));
    mtd_host host (
        .MCLK(mclk), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));

    task automatic conclude;
        if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic miss(input logic [31:0] g, input logic [31:0] e);
        err_total++;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) miss(g, e);
    endtask
    task automatic cmp_flag(input logic g, input logic e);
        cmp_count++;
        if (g !== e) miss(g, e);
    endtask
    task automatic cmp_cyc(input int g, input int e);
        cmp_count++;
        if (g != e) miss(g, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        cmp_reg(d, e);
    endtask
    task automatic steps(input int n);
        repeat (n) begin
            @(negedge mclk);
            while (step !== 1'b1) @(negedge mclk);
            @(posedge mclk);
            #1;
        end
    endtask
    task automatic period(input logic [7:0] ctl, input int e);
        int n;
        host.wr(8'h2A, ctl);
        steps(2);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (step !== 1'b1);
        cmp_cyc(n, e);
    endtask
    function automatic logic [35:0] ax(input logic [11:0] z, y, x);
        return {z, y, x};
    endfunction

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        nrst = 1'b0;
        raw = '0;
        hpf = '0;
        err_total = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (8) @(posedge mclk);
        #1;
        nrst = 1'b1;
        rd_chk(8'h17, 8'h00);
        rd_chk(8'h18, 8'h00);
        rd_chk(8'h1D, 8'h00);
        rd_chk(8'h30, 8'h00);
        host.wr(8'h1E, 8'hFF);
        rd_chk(8'h1E, 8'h00);
        period(8'h00, 50);
        period(8'h22, 100);
        period(8'h20, 800);
        period(8'h39, 3200);
        host.wr(8'h2A, 8'h00);
        // motion on x, count 3, decrementing
        host.wr(8'h15, 8'h48);
        host.wr(8'h17, 8'h10);
        host.wr(8'h18, 8'h03);
        rd_chk(8'h18, 8'h03);
        raw = ax(0, 0, 12'h200);
        steps(2);
        cmp_flag(mev, 1'b0);
        steps(1);
        cmp_flag(mev, 1'b1);
        steps(3);
        raw = '0;
        steps(1);
        raw = ax(0, 0, 12'h200);
        steps(1);
        cmp_flag(mev, 1'b1);
        // clearing mode: one miss restarts the count
        host.wr(8'h17, 8'h90);
        raw = '0;
        steps(1);
        raw = ax(0, 0, 12'h200);
        steps(1);
        cmp_flag(mev, 1'b0);
        steps(2);
        cmp_flag(mev, 1'b1);
        // freefall, count zero, threshold edge and sign
        host.wr(8'h15, 8'h38);
        host.wr(8'h18, 8'h00);
        raw = ax(0, 0, 12'h10F);
        steps(1);
        cmp_flag(mev, 1'b1);
        raw = ax(0, 0, 12'hEF0);
        steps(1);
        cmp_flag(mev, 1'b0);
        host.wr(8'h17, 8'h7F);
        raw = ax(12'h7F0, 12'h810, 12'h7FF);
        steps(1);
        cmp_flag(mev, 1'b1);
        // low noise caps the threshold at the 4 g count
        host.wr(8'h2A, 8'h04);
        steps(1);
        cmp_flag(mev, 1'b0);
        host.wr(8'h2A, 8'h00);
        // latched motion
        host.wr(8'h15, 8'hC8);
        host.wr(8'h17, 8'h10);
        raw = ax(0, 0, 12'h200);
        steps(1);
        raw = '0;
        steps(2);
        rd_chk(8'h16, 8'h82);
        cmp_flag(mev, 1'b0);
        rd_chk(8'h16, 8'h00);
        // transient, bypassed filter, latched, reserved bits dropped
        host.wr(8'h1F, 8'h10);
        host.wr(8'h20, 8'h00);
        host.wr(8'h1D, 8'hF3);
        rd_chk(8'h1D, 8'h13);
        raw = ax(0, 0, 12'hE00);
        steps(1);
        cmp_flag(tev, 1'b1);
        raw = '0;
        steps(2);
        rd_chk(8'h1E, 8'h43);
        cmp_flag(tev, 1'b0);
        rd_chk(8'h1E, 8'h00);
        // filtered data, only y enabled
        host.wr(8'h1D, 8'h14);
        hpf = ax(12'h400, 12'h200, 12'h400);
        steps(1);
        hpf = '0;
        steps(1);
        rd_chk(8'h1E, 8'h48);
        // further axes set and polarity refreshes while active
        host.wr(8'h1D, 8'h1E);
        hpf = ax(0, 0, 12'h200);
        steps(1);
        hpf = ax(0, 12'hE00, 12'hE00);
        steps(1);
        hpf = '0;
        steps(1);
        rd_chk(8'h1E, 8'h4F);
        // unlatched follows each sample
        host.wr(8'h1D, 8'h02);
        hpf = ax(0, 0, 12'h200);
        steps(1);
        cmp_flag(tev, 1'b1);
        hpf = '0;
        steps(1);
        cmp_flag(tev, 1'b0);
        conclude();
    end
endmodule
